// File: core/pvc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pvc_top import pvc_pkg::*; #(
   parameter int HOUR_CYCLES = HOUR_STEP_CYCLES,
   parameter int MINUTE_CYCLES = MIN_STEP_CYCLES,
   parameter logic [15:0] INRUSH_STEP = INRUSH_STEP_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [RAW_W-1:0] raw_value,
   input wire logic raw_valid,
   input wire logic input_disconnected,
   input wire logic nv_load_done,
   input wire logic nv_date_present,
   input wire logic nv_date_bad,
   input wire logic [31:0] nv_date,
   output logic nv_wr_req,
   output logic [31:0] nv_wr_data,
   input wire logic nv_wr_done,
   input wire logic nv_wr_fail,
   output logic signed [15:0] process_value,
   output logic high_high_limit_alarm,
   output logic high_limit_alarm,
   output logic low_limit_alarm,
   output logic low_low_limit_alarm,
   output logic unit_error_indicator
);
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [CTRL_W-1:0] ctrl;
      logic integ_clear;
      logic signed [15:0] range_min;
      logic signed [15:0] range_max;
      logic signed [15:0] alm_hh;
      logic signed [15:0] alm_h;
      logic signed [15:0] alm_l;
      logic signed [15:0] alm_ll;
      logic [15:0] raw;
      logic disc;
      logic busy;
      logic root_go;
      logic sqrt_mode;
      logic [15:0] prev_cond;
      logic started;
      logic inrush_armed;
      logic inrush_on;
      logic signed [15:0] pv;
      logic [3:0] alarms;
      pvc_nv_type nv_state;
      logic [31:0] adj_date;
      logic [31:0] wr_data;
      logic wr_req;
      logic update;
      logic nv_err;
      logic notice;
      logic expired;
      logic err_led;
   } pvc_top_state_type;

   pvc_top_state_type st_reg, st_next;
   pvc_calc_if calc ();

   logic setup;
   logic access_wr;
   logic [15:0] raw_c;
   logic next_mode;
   logic [15:0] cond;
   logic signed [31:0] span_v;
   logic signed [31:0] prod_v;
   logic signed [31:0] target_v;
   logic signed [15:0] target;
   logic signed [15:0] new_pv;
   int tgt_i;
   int pv_i;

   function automatic logic [3:0] pvc_eval_alarms(
      input logic signed [15:0] pv,
      input logic signed [15:0] hh,
      input logic signed [15:0] h,
      input logic signed [15:0] l,
      input logic signed [15:0] ll);
      logic [3:0] a;
      a[ALM_HH] = pv > hh;
      a[ALM_H] = pv > h;
      a[ALM_L] = pv < l;
      a[ALM_LL] = pv < ll;
      return a;
   endfunction

   function automatic logic pvc_addr_known(input logic [ADDR_W-1:0] a);
      logic k;
      case (a)
         ADDR_CTRL, ADDR_STATUS, ADDR_RANGE_MIN, ADDR_RANGE_MAX,
         ADDR_ALM_HH, ADDR_ALM_H, ADDR_ALM_L, ADDR_ALM_LL, ADDR_PV,
         ADDR_INTEG_LO, ADDR_INTEG_HI, ADDR_DATE_LO, ADDR_DATE_HI: begin
            k = 1'b1;
         end
         default: begin
            k = 1'b0;
         end
      endcase
      return k;
   endfunction

   function automatic logic [31:0] pvc_sext(input logic signed [15:0] v);
      return {{16{v[15]}}, v};
   endfunction

   pvc_root u_root (
      .clk(clk),
      .rst_n(rst_n),
      .calc(calc.root)
   );

   pvc_integ #(
      .HOUR_CYCLES(HOUR_CYCLES),
      .MINUTE_CYCLES(MINUTE_CYCLES)
   ) u_integ (
      .clk(clk),
      .rst_n(rst_n),
      .calc(calc.integ)
   );

   assign calc.root_start = st_reg.root_go;
   assign calc.root_operand = RAD_W'(st_reg.raw) * RAD_W'(RAW_SPAN_V);
   assign calc.integ_enable = st_reg.ctrl[CTRL_INTEG_EN];
   assign calc.integ_minute = st_reg.ctrl[CTRL_INTEG_MIN];
   assign calc.integ_clear = st_reg.integ_clear;
   assign calc.integ_sample = st_reg.pv;

   always_comb begin
      st_next = st_reg;
      setup = psel && !penable;
      access_wr = psel && penable && st_reg.pready && pwrite;
      st_next.pready = setup;
      st_next.pslverr = setup && !pvc_addr_known(paddr);
      st_next.root_go = 1'b0;
      st_next.integ_clear = 1'b0;

      // Read data is latched in the setup cycle and shown in the access one
      if (setup) begin
         case (paddr)
            ADDR_CTRL: st_next.prdata = 32'(st_reg.ctrl);
            ADDR_STATUS: st_next.prdata = 32'({st_reg.disc, st_reg.update,
               st_reg.expired, st_reg.notice, st_reg.nv_err,
               st_reg.sqrt_mode, st_reg.inrush_on, st_reg.alarms});
            ADDR_RANGE_MIN: st_next.prdata = pvc_sext(st_reg.range_min);
            ADDR_RANGE_MAX: st_next.prdata = pvc_sext(st_reg.range_max);
            ADDR_ALM_HH: st_next.prdata = pvc_sext(st_reg.alm_hh);
            ADDR_ALM_H: st_next.prdata = pvc_sext(st_reg.alm_h);
            ADDR_ALM_L: st_next.prdata = pvc_sext(st_reg.alm_l);
            ADDR_ALM_LL: st_next.prdata = pvc_sext(st_reg.alm_ll);
            ADDR_PV: st_next.prdata = pvc_sext(st_reg.pv);
            ADDR_INTEG_LO: st_next.prdata = {16'h0000, calc.integ_total[15:0]};
            ADDR_INTEG_HI:
               st_next.prdata = {16'h0000, calc.integ_total[31:16]};
            ADDR_DATE_LO: st_next.prdata = {16'h0000, st_reg.adj_date[15:0]};
            ADDR_DATE_HI: st_next.prdata = {16'h0000, st_reg.adj_date[31:16]};
            default: st_next.prdata = '0;
         endcase
      end

      if (access_wr) begin
         case (paddr)
            ADDR_CTRL: begin
               st_next.ctrl = pwdata[CTRL_W-1:0];
               st_next.integ_clear = pwdata[CTRL_INTEG_CLR];
            end
            ADDR_RANGE_MIN: st_next.range_min = pwdata[15:0];
            ADDR_RANGE_MAX: st_next.range_max = pwdata[15:0];
            ADDR_ALM_HH: st_next.alm_hh = pwdata[15:0];
            ADDR_ALM_H: st_next.alm_h = pwdata[15:0];
            ADDR_ALM_L: st_next.alm_l = pwdata[15:0];
            ADDR_ALM_LL: st_next.alm_ll = pwdata[15:0];
            ADDR_DATE_LO: begin
               // Word under write must stand still
               if (st_reg.nv_state != NV_WRITE) begin
                  st_next.wr_data[15:0] = pwdata[15:0];
               end
            end
            ADDR_DATE_HI: begin
               // High half commits the whole date to storage
               if (st_reg.nv_state == NV_IDLE) begin
                  st_next.wr_data[31:16] = pwdata[15:0];
                  st_next.nv_state = NV_WRITE;
                  st_next.wr_req = 1'b1;
                  st_next.update = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // Non-volatile adjustment date handling
      case (st_reg.nv_state)
         NV_LOAD: begin
            if (nv_load_done) begin
               st_next.nv_state = NV_IDLE;
               if (nv_date_bad) begin
                  st_next.err_led = 1'b1;
                  st_next.nv_err = 1'b1;
                  st_next.adj_date = DATE_BLANK;
                  st_next.notice = 1'b1;
                  st_next.expired = 1'b1;
               end else if (!nv_date_present) begin
                  st_next.adj_date = DATE_BLANK;
                  st_next.notice = 1'b1;
                  st_next.expired = 1'b1;
               end else begin
                  st_next.adj_date = nv_date;
                  st_next.notice = 1'b0;
                  st_next.expired = 1'b0;
               end
            end
         end
         NV_WRITE: begin
            // Request and update bit both hold until storage answers
            if (nv_wr_done) begin
               st_next.nv_state = NV_IDLE;
               st_next.wr_req = 1'b0;
               st_next.update = 1'b0;
               if (nv_wr_fail) begin
                  st_next.err_led = 1'b1;
                  st_next.nv_err = 1'b1;
                  st_next.adj_date = DATE_BLANK;
                  st_next.notice = 1'b1;
                  st_next.expired = 1'b1;
               end else begin
                  // Only a good rewrite clears the error
                  st_next.err_led = 1'b0;
                  st_next.nv_err = 1'b0;
                  st_next.adj_date = st_reg.wr_data;
                  st_next.notice = 1'b0;
                  st_next.expired = 1'b0;
               end
            end
         end
         NV_IDLE: begin
         end
         default: begin
            st_next.nv_state = NV_IDLE;
         end
      endcase

      // Sample capture; a sample arriving mid-calculation is dropped
      raw_c = (raw_value > RAW_SPAN_V) ? RAW_SPAN_V : raw_value;
      if (raw_valid && !st_reg.busy) begin
         st_next.raw = raw_c;
         st_next.disc = input_disconnected;
         st_next.busy = 1'b1;
         st_next.root_go = 1'b1;
      end

      // Hysteresis between linear and square-root transfer
      if (!st_reg.ctrl[CTRL_SQRT_EN]) begin
         next_mode = 1'b0;
      end else if (!st_reg.sqrt_mode) begin
         next_mode = st_reg.raw >= SQRT_ON_LEVEL;
      end else begin
         next_mode = !(st_reg.raw <= SQRT_OFF_LEVEL);
      end
      // Linear region keeps output equal to input
      cond = next_mode ? 16'(calc.root_value) : st_reg.raw;

      // A negative span flips the slope by itself
      span_v = 32'(st_reg.range_max) - 32'(st_reg.range_min);
      prod_v = $signed({16'h0000, cond}) * span_v;
      target_v = prod_v / RAW_SPAN + 32'(st_reg.range_min);
      target = target_v[15:0];
      tgt_i = int'(target);
      pv_i = int'(st_reg.pv);
      new_pv = target;

      if (calc.root_done && st_reg.busy) begin
         st_next.busy = 1'b0;
         st_next.sqrt_mode = next_mode;
         st_next.prev_cond = cond;
         if (!st_reg.started) begin
            st_next.started = 1'b1;
            // Already above the level at power-up: never arm
            st_next.inrush_armed = st_reg.ctrl[CTRL_INRUSH_EN] &&
                                   (cond < INRUSH_LEVEL);
         end else if (st_reg.inrush_armed && st_reg.prev_cond < INRUSH_LEVEL
                      && cond > INRUSH_LEVEL) begin
            st_next.inrush_armed = 1'b0;
            st_next.inrush_on = 1'b1;
         end
         // Limiting only slows the rise; it ends once caught up
         if (st_next.inrush_on) begin
            if (tgt_i > pv_i + int'(INRUSH_STEP)) begin
               new_pv = 16'(pv_i + int'(INRUSH_STEP));
            end else begin
               st_next.inrush_on = 1'b0;
            end
         end
         if (st_reg.disc) begin
            st_next.inrush_on = 1'b0;
            new_pv = st_reg.ctrl[CTRL_OVR_HIGH] ? st_reg.range_max
                                                : st_reg.range_min;
         end
         st_next.pv = new_pv;
         // Alarms follow the scaled value so inverted ranges behave alike
         st_next.alarms = pvc_eval_alarms(new_pv, st_reg.alm_hh,
            st_reg.alm_h, st_reg.alm_l, st_reg.alm_ll);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign nv_wr_req = st_reg.wr_req;
   assign nv_wr_data = st_reg.wr_data;
   assign process_value = st_reg.pv;
   assign high_high_limit_alarm = st_reg.alarms[ALM_HH];
   assign high_limit_alarm = st_reg.alarms[ALM_H];
   assign low_limit_alarm = st_reg.alarms[ALM_L];
   assign low_low_limit_alarm = st_reg.alarms[ALM_LL];
   assign unit_error_indicator = st_reg.err_led;
endmodule
`default_nettype wire

// File: core/pvc_pkg.sv
// How it works
// - Range maximum below minimum scales inversely; low input end gives the minimum.
// - Limit alarms compare the scaled process value, never the raw input.
// - High and high-high alarms set when value strictly exceeds setpoint.
// - Low and low-low alarms set when value strictly falls below setpoint.
// - Disconnection with overrange direction high reports the range maximum.
// - Disconnection with overrange direction low reports the range minimum.
// - Inrush limiting stays off if first value already exceeds two percent.
// - Inrush limiting engages only on a rise through two percent after startup.
// - Square-root mode passes input linearly near seven percent output or lower.
// - Rising input switches linear to square root at half a percent.
// - Falling input returns square root to linear only at 0.3 percent.
// - No stored date gives all-ones date and notice and expired flags set.
// - Faulty stored date lights error, sets storage error, blanks date, flags.
// - Failing date function keeps error lit until the host rewrites the date.
// - Update bit reads one throughout the storage write; host keeps power on.
// - Hourly mode accumulates every 3.6 s into a 32-bit two-word total.
// - Each step adds value over 1000; constant 1000 adds 1000 per unit.
// - Per-minute mode accumulates every 60 ms into the same total.
// - Total is signed 32 bits; beyond that range content is undefined.
package pvc_pkg;
   localparam int CLK_KHZ = 40000;
   localparam int HOUR_STEP_MS = 3600;
   localparam int MIN_STEP_MS = 60;
   localparam int HOUR_STEP_CYCLES = HOUR_STEP_MS * CLK_KHZ;
   localparam int MIN_STEP_CYCLES = MIN_STEP_MS * CLK_KHZ;
   localparam int INTEG_DIV = 1000;
   localparam int RAW_W = 16;
   localparam int ROOT_W = 14;
   localparam int RAD_W = 2 * ROOT_W;
   localparam int RAW_SPAN = 10000;
   localparam int PERMIL = 1000;
   localparam logic [15:0] INRUSH_LEVEL = 16'(RAW_SPAN * 20 / PERMIL);
   localparam logic [15:0] SQRT_ON_LEVEL = 16'(RAW_SPAN * 5 / PERMIL);
   localparam logic [15:0] SQRT_OFF_LEVEL = 16'(RAW_SPAN * 3 / PERMIL);
   localparam logic [15:0] RAW_SPAN_V = 16'(RAW_SPAN);
   localparam logic [15:0] INRUSH_STEP_DEF = 16'h0010;
   localparam logic [31:0] DATE_BLANK = 32'hFFFF_FFFF;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RANGE_MIN = 8'h08;
   localparam logic [7:0] ADDR_RANGE_MAX = 8'h0C;
   localparam logic [7:0] ADDR_ALM_HH = 8'h10;
   localparam logic [7:0] ADDR_ALM_H = 8'h14;
   localparam logic [7:0] ADDR_ALM_L = 8'h18;
   localparam logic [7:0] ADDR_ALM_LL = 8'h1C;
   localparam logic [7:0] ADDR_PV = 8'h20;
   localparam logic [7:0] ADDR_INTEG_LO = 8'h24;
   localparam logic [7:0] ADDR_INTEG_HI = 8'h28;
   localparam logic [7:0] ADDR_DATE_LO = 8'h2C;
   localparam logic [7:0] ADDR_DATE_HI = 8'h30;
   localparam int CTRL_W = 5;
   localparam int CTRL_INTEG_EN = 0;
   localparam int CTRL_INTEG_MIN = 1;
   localparam int CTRL_SQRT_EN = 2;
   localparam int CTRL_OVR_HIGH = 3;
   localparam int CTRL_INRUSH_EN = 4;
   localparam int CTRL_INTEG_CLR = 5;
   localparam int ST_ALARM = 0;
   localparam int ST_INRUSH = 4;
   localparam int ST_SQRT = 5;
   localparam int ST_NV_ERR = 6;
   localparam int ST_NOTICE = 7;
   localparam int ST_EXPIRED = 8;
   localparam int ST_UPDATE = 9;
   localparam int ST_DISC = 10;
   localparam int ST_W = 11;
   localparam int ALM_HH = 0;
   localparam int ALM_H = 1;
   localparam int ALM_L = 2;
   localparam int ALM_LL = 3;
   typedef enum logic [1:0] {NV_LOAD, NV_IDLE, NV_WRITE} pvc_nv_type;
endpackage

// File: core/pvc_calc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pvc_calc_if;
   import pvc_pkg::*;
   logic root_start;
   logic [RAD_W-1:0] root_operand;
   logic root_done;
   logic [ROOT_W-1:0] root_value;
   logic integ_enable;
   logic integ_minute;
   logic integ_clear;
   logic signed [15:0] integ_sample;
   logic [31:0] integ_total;
   modport top (output root_start, root_operand, integ_enable, integ_minute,
      integ_clear, integ_sample, input root_done, root_value, integ_total);
   modport root (input root_start, root_operand, output root_done,
      root_value);
   modport integ (input integ_enable, integ_minute, integ_clear,
      integ_sample, output integ_total);
endinterface
`default_nettype wire

// File: core/pvc_root.sv
`timescale 1ns/1ps
`default_nettype none
module pvc_root import pvc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   pvc_calc_if.root calc
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [3:0] idx;
      logic [ROOT_W-1:0] root;
      logic [RAD_W-1:0] rad;
   } pvc_root_state_type;

   pvc_root_state_type st_reg, st_next;
   logic [ROOT_W-1:0] trial;
   logic [RAD_W-1:0] trial_w;

   // One result bit per cycle; a multiplier beats a wide divider here
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      trial = st_reg.root | (ROOT_W'(1) << st_reg.idx);
      trial_w = RAD_W'(trial);
      if (!st_reg.busy) begin
         if (calc.root_start) begin
            st_next.busy = 1'b1;
            st_next.rad = calc.root_operand;
            st_next.root = '0;
            st_next.idx = 4'(ROOT_W - 1);
         end
      end else begin
         if (trial_w * trial_w <= st_reg.rad) begin
            st_next.root = trial;
         end
         if (st_reg.idx == '0) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end else begin
            st_next.idx = st_reg.idx - 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign calc.root_done = st_reg.done;
   assign calc.root_value = st_reg.root;
endmodule
`default_nettype wire

// File: core/pvc_integ.sv
`timescale 1ns/1ps
`default_nettype none
module pvc_integ import pvc_pkg::*; #(
   parameter int HOUR_CYCLES = HOUR_STEP_CYCLES,
   parameter int MINUTE_CYCLES = MIN_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   pvc_calc_if.integ calc
);
   typedef struct packed {
      logic [31:0] cnt;
      logic signed [31:0] total;
      logic signed [15:0] rem;
   } pvc_integ_state_type;

   pvc_integ_state_type st_reg, st_next;
   logic [31:0] period_last;
   int sum_v;
   int quot_v;

   always_comb begin
      st_next = st_reg;
      sum_v = int'(st_reg.rem) + int'(calc.integ_sample);
      quot_v = sum_v / INTEG_DIV;
      period_last = calc.integ_minute ? 32'(MINUTE_CYCLES - 1)
                                      : 32'(HOUR_CYCLES - 1);
      if (calc.integ_clear) begin
         st_next = '0;
      end else if (calc.integ_enable) begin
         if (st_reg.cnt >= period_last) begin
            st_next.cnt = '0;
            // Wraps silently past the signed range
            st_next.total = st_reg.total + quot_v;
            st_next.rem = 16'(sum_v - quot_v * INTEG_DIV);
         end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
         end
      end else begin
         st_next.cnt = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign calc.integ_total = st_reg.total;
endmodule
`default_nettype wire

// File: tb/pvc_nv_model.sv
`timescale 1ns/1ps
`default_nettype none
module pvc_nv_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bad,
   input wire logic fail,
   input wire logic nv_wr_req,
   output logic nv_load_done,
   output logic nv_date_present,
   output logic nv_date_bad,
   output logic [31:0] nv_date,
   output logic nv_wr_done,
   output logic nv_wr_fail
);
   int ld;
   int wt;
   always_ff @(posedge clk) begin
      ld <= rst_n ? ld + (ld < 9) : 0;
      wt <= (nv_wr_req && !nv_wr_done) ? wt + 1 : 0;
   end
   // Slow write keeps the busy window wide enough to poll
   assign nv_wr_done = wt == 12;
   assign nv_wr_fail = nv_wr_done ? fail : !fail;
   assign nv_load_done = ld == 4;
   // Unqualified lines show the inverse, never a stale value
   // Fail input doubles as date found at load
   assign nv_date_present = nv_load_done ? fail : !fail;
   assign nv_date_bad = nv_load_done ? bad : !bad;
   assign nv_date = {32{!nv_load_done}};
endmodule
`default_nettype wire

// File: tb/pvc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pvc_top_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic raw_valid,
   input wire logic signed [15:0] process_value,
   input wire logic high_limit_alarm,
   input wire logic nv_wr_req,
   input wire logic nv_wr_done,
   input wire logic nv_wr_fail,
   input wire logic nv_load_done,
   input wire logic nv_date_bad,
   input wire logic unit_error_indicator
);
   wire logic bad_ld = nv_load_done & nv_date_bad;
   wire logic bad_wr = nv_wr_done & nv_wr_fail;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && pready; endsequence
   property p_ready; s_setup |=> s_access; endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
   property p_single; pready |=> !pready; endproperty
   a_single: assert property (p_single) else $error("pready held");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr alone");
   property p_busy; nv_wr_req && !nv_wr_done |=> nv_wr_req; endproperty
   a_busy: assert property (p_busy) else $error("req dropped");
   property p_drop; nv_wr_req && nv_wr_done |=> !nv_wr_req; endproperty
   a_drop: assert property (p_drop) else $error("req kept");
   property p_pv; $changed(process_value) |-> $past(raw_valid, 17);
   endproperty
   a_pv: assert property (p_pv) else $error("pv off time");
   property p_alarm; $changed(high_limit_alarm) |-> $past(raw_valid, 17);
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm off time");
   property p_led;
      $rose(unit_error_indicator) |-> $past(bad_ld) || $past(bad_wr);
   endproperty
   a_led: assert property (p_led) else $error("led cause");
endmodule
bind pvc_top pvc_top_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr),
   .raw_valid(raw_valid), .process_value(process_value),
   .high_limit_alarm(high_limit_alarm), .nv_wr_req(nv_wr_req),
   .nv_wr_done(nv_wr_done), .nv_wr_fail(nv_wr_fail),
   .nv_load_done(nv_load_done), .nv_date_bad(nv_date_bad),
   .unit_error_indicator(unit_error_indicator));
`default_nettype wire

// File: tb/process_value_conditioning_bench.sv
`timescale 1ns/1ps
`default_nettype none
module process_value_conditioning_bench;
   import pvc_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic rv = 0, disc = 0, bad = 0, fail = 0, pready, pslverr;
   logic [7:0] paddr = 0;
   logic [15:0] raw = 0;
   logic [31:0] pwdata = 0, prdata, d, nd, wd;
   logic ld, pr, db, wq, wdn, wf, hh, h, l, ll, err;
   logic signed [15:0] pv;
   int mismatches = 0, tests_run = 0;
   logic [15:0] tr [13] = '{0, 2500, 2000, 7500, 8000, 10000, 5000,
      5000, 0, 40, 50, 40, 30};
   logic [15:0] te [13] = '{4000, 3000, 3200, 1000, 800, 0, 0, 4000,
      0, 40, 707, 632, 30};
   logic [3:0] ta [13] = '{12, 0, 4, 0, 2, 3, 3, 12, 3, 3, 2, 2, 3};
   always #12.5 clk = ~clk;
   pvc_top #(.HOUR_CYCLES(20), .MINUTE_CYCLES(8)) dut (.clk(clk),
      .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .raw_value(raw),
      .raw_valid(rv), .input_disconnected(disc), .nv_load_done(ld),
      .nv_date_present(pr), .nv_date_bad(db), .nv_date(nd),
      .nv_wr_req(wq), .nv_wr_data(wd), .nv_wr_done(wdn),
      .nv_wr_fail(wf), .process_value(pv), .high_high_limit_alarm(hh),
      .high_limit_alarm(h), .low_limit_alarm(l),
      .low_low_limit_alarm(ll), .unit_error_indicator(err));
   pvc_nv_model nv (.clk(clk), .rst_n(rst_n), .bad(bad), .fail(fail),
      .nv_wr_req(wq), .nv_load_done(ld), .nv_date_present(pr),
      .nv_date_bad(db), .nv_date(nd), .nv_wr_done(wdn), .nv_wr_fail(wf));
   // Read data carries pslverr in bit 0; mapped reads never set it
   task automatic apb(input logic [7:0] a, input logic w, logic [31:0] v);
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= v;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk);
      while (pready !== 1'b1);
      d = prdata | {31'h0, pslverr};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, logic [31:0] v);
      apb(a, 1'b1, v);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic cmp(input string s, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", s, e, g);
         mismatches++;
      end
   endtask
   task automatic cmpr(input string s, input logic [31:0] lo, hi, g);
      tests_run++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         $display("[FAIL] %s exp %0d..%0d got %0d", s, lo, hi, g);
         mismatches++;
      end
   endtask
   task automatic feed(input logic [15:0] v, input logic dc);
      @(posedge clk);
      raw <= v;
      disc <= dc;
      rv <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
      repeat (20) @(posedge clk);
   endtask
   task automatic rst();
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask
   task automatic date(input logic [15:0] v);
      wr(ADDR_DATE_LO, {16'h0, v});
      wr(ADDR_DATE_HI, 32'h1);
      repeat (3) @(posedge clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #500000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      rst();
      rd(ADDR_STATUS);
      cmp("flags", 32'h180, d & 32'h7C0);
      rd(ADDR_DATE_HI);
      cmp("date", 32'hFFFF, d);
      rd(8'h3C);
      cmp("unmapped", 32'h1, d);
      $display("done reset");
      wr(ADDR_RANGE_MIN, 32'd4000);
      wr(ADDR_ALM_HH, 32'd3500);
      wr(ADDR_ALM_H, 32'd3000);
      wr(ADDR_ALM_L, 32'd1000);
      wr(ADDR_ALM_LL, 32'd500);
      for (int i = 0; i < 13; i++) begin
         if (i == 6) wr(ADDR_CTRL, 32'h8);
         if (i == 7) wr(ADDR_CTRL, 32'h0);
         if (i == 8) wr(ADDR_RANGE_MIN, 32'h0);
         if (i == 8) wr(ADDR_RANGE_MAX, 32'd10000);
         if (i == 8) wr(ADDR_CTRL, 32'h4);
         feed(tr[i], i == 6 || i == 7);
         cmp("pv", {12'h0, ta[i], te[i]}, {12'h0, hh, h, l, ll, pv});
      end
      $display("done scaling");
      for (int k = 0; k < 2; k++) begin
         rst();
         wr(ADDR_RANGE_MAX, 32'd10000);
         wr(ADDR_CTRL, 32'h10);
         if (k == 1) feed(16'd0, 1'b0);
         feed(16'd5000, 1'b0);
         rd(ADDR_STATUS);
         cmp("inrush", {27'h0, k[0], 4'h0}, d & 32'h10);
      end
      $display("done inrush");
      date(16'h1234);
      rd(ADDR_STATUS);
      cmp("updating", 32'h200, d & 32'h200);
      cmp("wr_data", 32'h0001_1234, wd);
      repeat (20) @(posedge clk);
      rd(ADDR_STATUS);
      cmp("stored", 32'h0, d & 32'h3C0);
      rd(ADDR_DATE_LO);
      cmp("date_lo", 32'h1234, d);
      fail <= 1'b1;
      date(16'h4321);
      repeat (20) @(posedge clk);
      rd(ADDR_STATUS);
      cmp("nv_err", 32'h40, d & 32'h40);
      cmp("led", 32'h1, {31'h0, err});
      fail <= 1'b0;
      bad <= 1'b1;
      rst();
      rd(ADDR_STATUS);
      cmp("bad_flags", 32'h1C0, d & 32'h1C0);
      rd(ADDR_DATE_LO);
      cmp("bad_date", 32'hFFFF, d);
      cmp("bad_led", 32'h1, {31'h0, err});
      bad <= 1'b0;
      date(16'h0042);
      repeat (20) @(posedge clk);
      cmp("led_off", 32'h0, {31'h0, err});
      fail <= 1'b1;
      rst();
      rd(ADDR_STATUS);
      cmp("present", 32'h0, d & 32'h1C0);
      fail <= 1'b0;
      $display("done storage");
      wr(ADDR_RANGE_MAX, 32'd10000);
      feed(16'd1500, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CTRL, 32'h20);
         wr(ADDR_CTRL, {30'h0, k[0], 1'b1});
         repeat (400) @(posedge clk);
         wr(ADDR_CTRL, 32'h0);
         rd(ADDR_INTEG_LO);
         if (k == 0) cmpr("hour", 32'd28, 32'd31, d);
         else cmpr("minute", 32'd73, 32'd76, d);
      end
      $display("done integration");
      tally_and_finish();
   end
endmodule
`default_nettype wire
